// ---- pkg/tmw_pkg.sv ----
// Package for the 8-bit waveform timer: register map, fields, modes, prescale.
// Assumes a plain register port with 8-bit data and one 50 MHz clock.
package tmw_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_WAVE_CTRL_A = 8'h24;
  localparam logic [7:0] REG_WAVE_CTRL_B = 8'h25;
  localparam logic [7:0] REG_COUNTER = 8'h26;
  localparam logic [7:0] REG_COMPARE_A = 8'h27;
  localparam logic [7:0] REG_COMPARE_B = 8'h28;
  localparam logic [7:0] REG_FLAGS = 8'h35;
  localparam logic [7:0] REG_PIN_DIR = 8'h29;
  // ==========================================================
  // Field positions
  localparam int CA_MODE_HI = 7;
  localparam int CA_MODE_LO = 6;
  localparam int CB_MODE_HI = 5;
  localparam int CB_MODE_LO = 4;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WM_BIT2 = 3;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MA = 1;
  localparam int FLAG_MB = 2;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0f;
  localparam logic [7:0] FLAGS_MASK = 8'h07;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // ==========================================================
  // Counter limits
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // ==========================================================
  // Waveform modes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PC_FF = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_FF = 3'h3;
  localparam logic [2:0] WM_PC_CMP = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;
  // ==========================================================
  // Clock select codes and prescale divisors
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_MASK8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_MASK64 = 10'h03f;
  localparam logic [PRE_W-1:0] PRE_MASK256 = 10'h0ff;
  localparam logic [PRE_W-1:0] PRE_MASK1024 = 10'h3ff;
  // ==========================================================
  // Output action per channel event
  typedef enum logic [3:0] {
    TMW_ACT_NONE = 4'b0001,
    TMW_ACT_TOGGLE = 4'b0010,
    TMW_ACT_CLEAR = 4'b0100,
    TMW_ACT_SET = 4'b1000
  } tmw_act_t;
endpackage

// ---- rtl/tmw_wave_chan.sv ----
// One compare channel: compare register, buffered update, and waveform output.
// Assumes the timer core supplies tick, counter, direction and mode decodes.
`timescale 1ns/1ns
module tmw_wave_chan
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Compare register access
  input wire logic cmp_wr,
  input wire logic [7:0] cmp_wdata,
  output logic [7:0] cmp_val_ff,
  // Timer state
  input wire logic tick,
  input wire logic [7:0] count,
  input wire logic [7:0] top_val,
  input wire logic at_top_load,
  input wire logic buffered,
  input wire logic pwm_fast,
  input wire logic pwm_pc,
  input wire logic counting_down,
  input wire logic match_blocked,
  input wire logic wrap_event,
  input wire logic toggle_ok,
  input wire logic [1:0] out_mode,
  input wire logic force_strobe,
  // Results
  output logic match_hit,
  output logic wave_ff
);
  logic [7:0] cmp_buf_ff;
  logic [7:0] nxt_cmp_val;
  logic nxt_wave;
  logic is_pwm;
  logic cmp_eq;
  logic top_special;
  tmw_act_t act;

  // Buffered in PWM modes so a new duty cycle never glitches mid-period
  assign is_pwm = pwm_fast | pwm_pc;
  assign nxt_cmp_val = (!buffered) ? cmp_buf_ff : (at_top_load ? cmp_buf_ff : cmp_val_ff);
  assign cmp_eq = (count == cmp_val_ff);
  assign match_hit = tick & cmp_eq & ~match_blocked;
  assign top_special = is_pwm & out_mode[1] & (cmp_val_ff == top_val);

  always_comb begin
    act = TMW_ACT_NONE;
    if (!is_pwm) begin
      if ((match_hit | force_strobe) && out_mode != 2'b00) begin
        unique case (out_mode)
          2'b01: act = TMW_ACT_TOGGLE;
          2'b10: act = TMW_ACT_CLEAR;
          default: act = TMW_ACT_SET;
        endcase
      end
    end else if (out_mode == 2'b01) begin
      if (match_hit && toggle_ok) begin
        act = TMW_ACT_TOGGLE;
      end
    end else if (out_mode[1]) begin
      if (pwm_fast) begin
        if (match_hit && !top_special) begin
          act = out_mode[0] ? TMW_ACT_SET : TMW_ACT_CLEAR;
        end else if (wrap_event) begin
          act = out_mode[0] ? TMW_ACT_CLEAR : TMW_ACT_SET;
        end
      end else if (top_special) begin
        if (tick && count == top_val) begin
          act = out_mode[0] ? TMW_ACT_CLEAR : TMW_ACT_SET;
        end
      end else if (match_hit) begin
        act = (counting_down ^ out_mode[0]) ? TMW_ACT_SET : TMW_ACT_CLEAR;
      end
    end
    unique case (act)
      TMW_ACT_TOGGLE: nxt_wave = ~wave_ff;
      TMW_ACT_CLEAR: nxt_wave = 1'b0;
      TMW_ACT_SET: nxt_wave = 1'b1;
      default: nxt_wave = wave_ff;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_buf_ff <= RESET_VAL;
      cmp_val_ff <= RESET_VAL;
      wave_ff <= 1'b0;
    end else begin
      if (cmp_wr) begin
        cmp_buf_ff <= cmp_wdata;
      end
      cmp_val_ff <= (cmp_wr && !buffered) ? cmp_wdata : nxt_cmp_val;
      wave_ff <= nxt_wave;
    end
  end
endmodule

// ---- rtl/tmw_timer8.sv ----
// 8-bit waveform timer: registers, prescaler, external count input, counter.
// Assumes a one-cycle register port and an external count pin from off-chip.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module tmw_timer8
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Interrupt vector acknowledges
  input wire logic ack_overflow,
  input wire logic ack_match_a,
  input wire logic ack_match_b,
  // Pins
  input wire logic ext_count_pin,
  output logic wave_out_a_ff,
  output logic wave_out_a_oe_ff,
  output logic wave_out_b_ff,
  output logic wave_out_b_oe_ff,
  // Flags to the interrupt controller
  output logic overflow_flag_ff,
  output logic match_a_flag_ff,
  output logic match_b_flag_ff
);
  // ==========================================================
  // Registers
  logic [7:0] ctrl_a_ff;
  logic [3:0] ctrl_b_ff;
  logic [7:0] counter_value_ff;
  logic [1:0] pin_dir_ff;
  logic count_down_ff;
  logic blk_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [2:0] ext_sync_ff;
  logic ext_level_ff;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic wave_a;
  logic wave_b;
  logic hit_a;
  logic hit_b;

  // ==========================================================
  // Decode
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  logic [2:0] waveform_mode_sel;
  logic [2:0] count_clock_sel;
  logic waveform_mode_bit2;
  logic wr_ca;
  logic wr_cb;
  logic wr_cnt;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_flg;
  logic wr_dir;
  logic pwm_fast;
  logic pwm_pc;
  logic non_pwm;
  logic top_cmp;
  logic [7:0] top_val;
  logic force_a;
  logic force_b;
  logic ext_rise;
  logic ext_fall;
  logic pre_tick;
  logic tick;
  logic at_top;
  logic at_bottom;
  logic wrap_event;
  logic ovf_event;
  logic ctc_clear;
  logic top_load;
  logic buffered;
  logic [7:0] nxt_count;
  logic nxt_down;
  logic [7:0] nxt_rdata;
  logic mode_ctc;
  logic mode_fast_cmp;
  logic pin_a_claim;
  logic pin_b_claim;

  // Up or down by one; shared by both slopes of the counter
  function automatic logic [7:0] count_step(input logic [7:0] v, input logic down);
    return down ? v - CNT_ONE : v + CNT_ONE;
  endfunction

  assign chan_a_output_mode = ctrl_a_ff[CA_MODE_HI:CA_MODE_LO];
  assign chan_b_output_mode = ctrl_a_ff[CB_MODE_HI:CB_MODE_LO];
  assign waveform_mode_bit2 = ctrl_b_ff[WM_BIT2];
  assign waveform_mode_sel = {waveform_mode_bit2, ctrl_a_ff[1:0]};
  assign count_clock_sel = ctrl_b_ff[2:0];

  assign wr_ca = reg_wr & (reg_addr == REG_WAVE_CTRL_A);
  assign wr_cb = reg_wr & (reg_addr == REG_WAVE_CTRL_B);
  assign wr_cnt = reg_wr & (reg_addr == REG_COUNTER);
  assign wr_cmpa = reg_wr & (reg_addr == REG_COMPARE_A);
  assign wr_cmpb = reg_wr & (reg_addr == REG_COMPARE_B);
  assign wr_flg = reg_wr & (reg_addr == REG_FLAGS);
  assign wr_dir = reg_wr & (reg_addr == REG_PIN_DIR);

  // Reserved codes 4 and 6 behave exactly as normal mode
  assign pwm_fast = (waveform_mode_sel == WM_FAST_FF) | (waveform_mode_sel == WM_FAST_CMP);
  assign pwm_pc = (waveform_mode_sel == WM_PC_FF) | (waveform_mode_sel == WM_PC_CMP);
  assign non_pwm = ~pwm_fast & ~pwm_pc;
  assign mode_ctc = (waveform_mode_sel == WM_CTC);
  assign mode_fast_cmp = (waveform_mode_sel == WM_FAST_CMP);
  assign top_cmp = (waveform_mode_sel == WM_CTC) | (waveform_mode_sel == WM_PC_CMP)
                 | (waveform_mode_sel == WM_FAST_CMP);
  assign top_val = top_cmp ? cmp_a : CNT_MAX;
  // Reserved codes load the compare at once, as the non-PWM modes do
  assign buffered = pwm_fast | pwm_pc;

  // Strobes only act in non-PWM modes and never touch flags or counter
  assign force_a = wr_cb & reg_wdata[FORCE_A_BIT] & non_pwm;
  assign force_b = wr_cb & reg_wdata[FORCE_B_BIT] & non_pwm;

  // ==========================================================
  // Clock selection
  // Edges use stages 2 and 3 only, so stage 1 metastability never leaks
  // A new level counts once stages 2 and 3 agree, so a runt pulse is dropped
  assign ext_rise = ext_sync_ff[2] & ext_sync_ff[1] & ~ext_level_ff;
  assign ext_fall = ~ext_sync_ff[2] & ~ext_sync_ff[1] & ext_level_ff;

  always_comb begin
    unique case (count_clock_sel)
      CS_STOP: pre_tick = 1'b0;
      CS_DIV1: pre_tick = 1'b1;
      CS_DIV8: pre_tick = ((pre_ff & PRE_MASK8) == PRE_MASK8);
      CS_DIV64: pre_tick = ((pre_ff & PRE_MASK64) == PRE_MASK64);
      CS_DIV256: pre_tick = ((pre_ff & PRE_MASK256) == PRE_MASK256);
      CS_DIV1024: pre_tick = (pre_ff == PRE_MASK1024);
      CS_EXT_FALL: pre_tick = ext_fall;
      default: pre_tick = ext_rise;
    endcase
  end
  assign tick = pre_tick;

  // ==========================================================
  // Counting sequence
  assign at_top = (counter_value_ff == top_val);
  assign at_bottom = (counter_value_ff == CNT_BOTTOM);
  assign wrap_event = tick & pwm_fast & at_top;
  // Fast PWM restarts from its top as clear-on-match does from compare A
  assign ctc_clear = tick & at_top & (mode_ctc | pwm_fast);
  assign top_load = tick & (pwm_pc ? at_top : at_top & pwm_fast);
  // Overflow point depends on mode; a stopped counter never ticks
  assign ovf_event = tick & (pwm_pc ? (at_bottom & count_down_ff)
                 : mode_fast_cmp ? at_top
                 : (counter_value_ff == CNT_MAX));

  always_comb begin
    nxt_count = counter_value_ff;
    nxt_down = count_down_ff;
    if (wr_cnt) begin
      nxt_count = reg_wdata;
    end else if (tick) begin
      if (pwm_pc) begin
        if (!count_down_ff && at_top) begin
          nxt_down = 1'b1;
          nxt_count = count_step(counter_value_ff, 1'b1);
        end else if (count_down_ff && at_bottom) begin
          nxt_down = 1'b0;
          nxt_count = count_step(counter_value_ff, 1'b0);
        end else begin
          nxt_count = count_step(counter_value_ff, count_down_ff);
        end
      end else begin
        nxt_down = 1'b0;
        nxt_count = ctc_clear ? CNT_BOTTOM : counter_value_ff + CNT_ONE;
      end
    end
  end

  // ==========================================================
  // Compare channels
  tmw_wave_chan u_chan_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .cmp_wr(wr_cmpa),
    .cmp_wdata(reg_wdata),
    .cmp_val_ff(cmp_a),
    .tick(tick),
    .count(counter_value_ff),
    .top_val(top_val),
    .at_top_load(top_load),
    .buffered(buffered),
    .pwm_fast(pwm_fast),
    .pwm_pc(pwm_pc),
    .counting_down(count_down_ff),
    .match_blocked(blk_ff),
    .wrap_event(wrap_event),
    .toggle_ok(waveform_mode_bit2),
    .out_mode(chan_a_output_mode),
    .force_strobe(force_a),
    .match_hit(hit_a),
    .wave_ff(wave_a)
  );

  // Toggle is reserved on channel B in the PWM modes
  tmw_wave_chan u_chan_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .cmp_wr(wr_cmpb),
    .cmp_wdata(reg_wdata),
    .cmp_val_ff(cmp_b),
    .tick(tick),
    .count(counter_value_ff),
    .top_val(top_val),
    .at_top_load(top_load),
    .buffered(buffered),
    .pwm_fast(pwm_fast),
    .pwm_pc(pwm_pc),
    .counting_down(count_down_ff),
    .match_blocked(blk_ff),
    .wrap_event(wrap_event),
    .toggle_ok(1'b0),
    .out_mode(chan_b_output_mode),
    .force_strobe(force_b),
    .match_hit(hit_b),
    .wave_ff(wave_b)
  );

  // ==========================================================
  // Read mux
  // Data drops back to zero after the read cycle
  always_comb begin
    nxt_rdata = RESET_VAL;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_WAVE_CTRL_A: nxt_rdata = ctrl_a_ff & CTRL_A_MASK;
        REG_WAVE_CTRL_B: nxt_rdata = {4'h0, ctrl_b_ff};
        REG_COUNTER: nxt_rdata = counter_value_ff;
        REG_COMPARE_A: nxt_rdata = cmp_a;
        REG_COMPARE_B: nxt_rdata = cmp_b;
        REG_FLAGS: nxt_rdata = {5'h00, match_b_flag_ff, match_a_flag_ff, overflow_flag_ff};
        REG_PIN_DIR: nxt_rdata = {6'h00, pin_dir_ff};
        default: nxt_rdata = RESET_VAL;
      endcase
    end
  end

  // ==========================================================
  // State
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_ff <= RESET_VAL;
      ctrl_b_ff <= 4'h0;
      pin_dir_ff <= 2'b00;
      counter_value_ff <= RESET_VAL;
      count_down_ff <= 1'b0;
      blk_ff <= 1'b0;
      pre_ff <= '0;
      ext_sync_ff <= 3'b000;
      ext_level_ff <= 1'b0;
      reg_rdata_ff <= RESET_VAL;
    end else begin
      if (wr_ca) begin
        ctrl_a_ff <= reg_wdata & CTRL_A_MASK;
      end
      if (wr_cb) begin
        ctrl_b_ff <= reg_wdata[3:0];
      end
      if (wr_dir) begin
        pin_dir_ff <= reg_wdata[1:0];
      end
      counter_value_ff <= nxt_count;
      count_down_ff <= nxt_down;
      // Block lasts until the next timer tick after a counter write
      blk_ff <= wr_cnt ? 1'b1 : (tick ? 1'b0 : blk_ff);
      // Prescaler keeps its phase across select changes
      pre_ff <= (count_clock_sel == CS_STOP) ? pre_ff : pre_ff + 10'h001;
      ext_sync_ff <= {ext_sync_ff[1:0], ext_count_pin};
      ext_level_ff <= (ext_sync_ff[1] == ext_sync_ff[2]) ? ext_sync_ff[2] : ext_level_ff;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Flags: set wins over clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_ff <= 1'b0;
      match_a_flag_ff <= 1'b0;
      match_b_flag_ff <= 1'b0;
    end else begin
      overflow_flag_ff <= ovf_event | (overflow_flag_ff & ~ack_overflow
                        & ~(wr_flg & reg_wdata[FLAG_OVF]));
      match_a_flag_ff <= hit_a | (match_a_flag_ff & ~ack_match_a
                       & ~(wr_flg & reg_wdata[FLAG_MA]));
      match_b_flag_ff <= hit_b | (match_b_flag_ff & ~ack_match_b
                       & ~(wr_flg & reg_wdata[FLAG_MB]));
    end
  end

  // ==========================================================
  // Pin drive
  assign pin_a_claim = (chan_a_output_mode != 2'b00) & pin_dir_ff[0];
  assign pin_b_claim = (chan_b_output_mode != 2'b00) & pin_dir_ff[1];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wave_out_a_ff <= 1'b0;
      wave_out_a_oe_ff <= 1'b0;
      wave_out_b_ff <= 1'b0;
      wave_out_b_oe_ff <= 1'b0;
    end else begin
      wave_out_a_ff <= wave_a;
      wave_out_a_oe_ff <= pin_a_claim;
      wave_out_b_ff <= wave_b;
      wave_out_b_oe_ff <= pin_b_claim;
    end
  end
endmodule

// ---- test/tmw_timer8_assertions.sv ----
// Checker for the 8-bit waveform timer, watching only its top-level ports.
// Assumes one clock domain and a one-cycle strobe register port.
`timescale 1ns/1ns
module tmw_timer8_chk
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // Acknowledges and pins
  input wire logic ack_overflow,
  input wire logic ack_match_a,
  input wire logic ack_match_b,
  input wire logic ext_count_pin,
  input wire logic wave_out_a_ff,
  input wire logic wave_out_a_oe_ff,
  input wire logic wave_out_b_ff,
  input wire logic wave_out_b_oe_ff,
  // Flags
  input wire logic overflow_flag_ff,
  input wire logic match_a_flag_ff,
  input wire logic match_b_flag_ff
);
  // ==========
  // Shadow registers
  logic [7:0] sh_a_ff, sh_b_ff, sh_c_ff;
  logic [3:0] stop_ff, za_ff, zb_ff;
  wire wr_a = reg_wr && reg_addr == REG_WAVE_CTRL_A;
  wire wr_b = reg_wr && reg_addr == REG_WAVE_CTRL_B;
  wire wr_c = reg_wr && reg_addr == REG_COMPARE_A;
  wire [2:0] mode = {sh_b_ff[WM_BIT2], sh_a_ff[1:0]};
  wire unbuf = mode == WM_NORMAL || mode == WM_CTC;
  wire stopped = stop_ff == 4'hf;
  // Quiet counts saturate; ticks still in flight settle well within 15
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {sh_a_ff, sh_b_ff, sh_c_ff} <= 24'h000000;
      {stop_ff, za_ff, zb_ff} <= 12'h000;
    end else begin
      if (wr_a) sh_a_ff <= reg_wdata;
      if (wr_b) sh_b_ff <= reg_wdata;
      if (wr_c) sh_c_ff <= reg_wdata;
      stop_ff <= (sh_b_ff[2:0] != CS_STOP) ? 4'h0 : stop_ff + {3'h0, !stopped};
      za_ff <= (sh_a_ff[7:6] != 2'h0) ? 4'h0 : za_ff + {3'h0, za_ff != 4'hf};
      zb_ff <= (sh_a_ff[5:4] != 2'h0) ? 4'h0 : zb_ff + {3'h0, zb_ff != 4'hf};
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  AST_CTRL_A_READ: assert property (
    s_rd(REG_WAVE_CTRL_A) |=> reg_rdata_ff == (sh_a_ff & CTRL_A_MASK))
    else $error("control A readback wrong");
  AST_CTRL_B_READ: assert property (
    s_rd(REG_WAVE_CTRL_B) |=> reg_rdata_ff == (sh_b_ff & CTRL_B_MASK))
    else $error("control B readback wrong");
  AST_CMP_READ: assert property (
    unbuf ##0 s_rd(REG_COMPARE_A) |=> reg_rdata_ff == sh_c_ff)
    else $error("compare A readback wrong");
  AST_UNMAPPED_READ: assert property (s_rd(8'h30) |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  AST_OE_A_OFF: assert property (
    za_ff == 4'hf |-> !wave_out_a_oe_ff)
    else $error("pin A driven with mode zero");
  AST_OE_B_OFF: assert property (
    zb_ff == 4'hf |-> !wave_out_b_oe_ff)
    else $error("pin B driven with mode zero");
  AST_STOP_NO_FLAG: assert property (
    stopped |-> !$rose(overflow_flag_ff) && !$rose(match_a_flag_ff) && !$rose(match_b_flag_ff))
    else $error("flag rose while stopped");
  AST_ACK_CLEAR: assert property (
    stopped && ack_overflow |=> !overflow_flag_ff)
    else $error("acknowledge did not clear overflow");
  AST_W1C_MATCH_A: assert property (
    stopped && reg_wr && reg_addr == REG_FLAGS && reg_wdata[FLAG_MA] |=> !match_a_flag_ff)
    else $error("write one did not clear match A");
  AST_RESET_OUTS: assert property (
    $rose(rst_n) |-> reg_rdata_ff == 8'h00 && {overflow_flag_ff, match_a_flag_ff,
      match_b_flag_ff, wave_out_a_ff, wave_out_a_oe_ff, wave_out_b_ff,
      wave_out_b_oe_ff} == 7'h00)
    else $error("outputs not zero after reset");
endmodule
bind tmw_timer8 tmw_timer8_chk u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .ack_overflow(ack_overflow), .ack_match_a(ack_match_a), .ack_match_b(ack_match_b),
  .ext_count_pin(ext_count_pin), .wave_out_a_ff(wave_out_a_ff),
  .wave_out_a_oe_ff(wave_out_a_oe_ff), .wave_out_b_ff(wave_out_b_ff),
  .wave_out_b_oe_ff(wave_out_b_oe_ff), .overflow_flag_ff(overflow_flag_ff),
  .match_a_flag_ff(match_a_flag_ff), .match_b_flag_ff(match_b_flag_ff));

// ---- test/testbench.sv ----
// Self-checking bench for the 8-bit waveform timer.
// Assumes the checker file is compiled with it and binds itself.
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench
  import tmw_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] acks = 3'h0;
  logic ext_count_pin = 1'b0;
  logic [7:0] reg_rdata_ff, d;
  logic wave_out_a_ff, wave_out_a_oe_ff, wave_out_b_ff, wave_out_b_oe_ff;
  logic overflow_flag_ff, match_a_flag_ff, match_b_flag_ff;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int hi;
  int divs [6] = '{1, 1, 8, 64, 256, 1024};
  logic [7:0] regs [6] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h35};
  logic [7:0] fa [4] = '{8'ha2, 8'h52, 8'h52, 8'hf2};
  logic [1:0] fw [4] = '{2'b00, 2'b11, 2'b00, 2'b11};
  // Duty rows: control A, control B, compare A, compare B
  logic [31:0] tr [7] = '{32'h83018000, 32'hc3018000, 32'h81014000, 32'h87092000,
    32'h23010080, 32'h31010040, 32'h41094000};
  int tx [7] = '{516, 508, 256, 1024, 516, 768, 512};
  always #10 mclk = ~mclk;
  tmw_timer8 dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .ack_overflow(acks[0]), .ack_match_a(acks[1]), .ack_match_b(acks[2]),
    .ext_count_pin(ext_count_pin), .wave_out_a_ff(wave_out_a_ff),
    .wave_out_a_oe_ff(wave_out_a_oe_ff), .wave_out_b_ff(wave_out_b_ff),
    .wave_out_b_oe_ff(wave_out_b_oe_ff), .overflow_flag_ff(overflow_flag_ff),
    .match_a_flag_ff(match_a_flag_ff), .match_b_flag_ff(match_b_flag_ff));
  // ==========
  // Bus tasks
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata_ff;
  endtask
  task cr(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK($sformatf("reg_%h", a), e, d)
  endtask
  // Stop, then let any tick still in flight land
  task stop();
    wr(REG_WAVE_CTRL_B, 8'h00);
    cyc(20);
  endtask
  task run(input logic [7:0] cnt, input logic [7:0] cs, input int n);
    wr(REG_COUNTER, cnt);
    wr(REG_WAVE_CTRL_B, cs);
    cyc(n);
    stop();
  endtask
  task report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ==========
  // Main sequence
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    foreach (regs[i]) cr(regs[i], 8'h00);
    wr(REG_WAVE_CTRL_A, 8'hff);
    cr(REG_WAVE_CTRL_A, 8'hf3);
    wr(REG_WAVE_CTRL_A, 8'h00);
    wr(REG_WAVE_CTRL_B, 8'hf8);
    cr(REG_WAVE_CTRL_B, 8'h08);
    wr(REG_WAVE_CTRL_B, 8'h00);
    wr(REG_COMPARE_A, 8'h5a);
    cr(REG_COMPARE_A, 8'h5a);
    wr(8'h30, 8'hff);
    cr(8'h30, 8'h00);
    wr(REG_COUNTER, 8'h40);
    cyc(50);
    cr(REG_COUNTER, 8'h40);
    for (int i = 1; i <= 5; i++) begin
      run(8'h00, 8'(i), 8 * divs[i]);
      rd(REG_COUNTER);
      `CHK("prescaled count", 1'b1, d >= 8'h07 && d <= 8'h0b)
    end
    // Pin set as output must still clock the counter
    wr(REG_PIN_DIR, 8'hff);
    for (int e = 6; e <= 7; e++) begin
      wr(REG_COUNTER, 8'h00);
      wr(REG_WAVE_CTRL_B, 8'(e));
      repeat (6) begin
        ext_count_pin <= 1'b1;
        cyc(6);
        ext_count_pin <= 1'b0;
        cyc(6);
      end
      cyc(10);
      stop();
      cr(REG_COUNTER, 8'h06);
    end
    run(8'hfd, 8'h01, 10);
    rd(REG_FLAGS);
    `CHK("overflow set", 1'b1, d[FLAG_OVF])
    wr(REG_FLAGS, 8'h01);
    cr(REG_FLAGS, 8'h04);
    wr(REG_COMPARE_A, 8'h10);
    wr(REG_COMPARE_B, 8'h12);
    wr(REG_PIN_DIR, 8'h03);
    wr(REG_WAVE_CTRL_A, 8'h50);
    run(8'h0c, 8'h01, 12);
    cr(REG_FLAGS, 8'h06);
    `CHK("wave pins", 4'hf, {wave_out_a_ff, wave_out_a_oe_ff, wave_out_b_ff, wave_out_b_oe_ff})
    @(posedge mclk);
    acks <= 3'h6;
    @(posedge mclk);
    acks <= 3'h0;
    cr(REG_FLAGS, 8'h00);
    wr(REG_PIN_DIR, 8'h00);
    cyc(4);
    `CHK("direction gate", 2'b00, {wave_out_a_oe_ff, wave_out_b_oe_ff})
    wr(REG_COUNTER, 8'h33);
    for (int k = 0; k < 4; k++) begin
      wr(REG_WAVE_CTRL_A, fa[k]);
      wr(REG_WAVE_CTRL_B, 8'hc0);
      cyc(4);
      `CHK("forced waves", fw[k], {wave_out_a_ff, wave_out_b_ff})
    end
    cr(REG_COUNTER, 8'h33);
    cr(REG_FLAGS, 8'h00);
    cr(REG_WAVE_CTRL_B, 8'h00);
    wr(REG_WAVE_CTRL_A, 8'ha3);
    wr(REG_WAVE_CTRL_B, 8'hc0);
    cyc(4);
    `CHK("pwm force ignored", 2'b11, {wave_out_a_ff, wave_out_b_ff})
    wr(REG_WAVE_CTRL_A, 8'h02);
    wr(REG_FLAGS, 8'h07);
    run(8'h00, 8'h01, 300);
    rd(REG_COUNTER);
    `CHK("ctc bound", 1'b1, d <= 8'h10)
    rd(REG_FLAGS);
    `CHK("ctc no overflow", 1'b0, d[FLAG_OVF])
    wr(REG_WAVE_CTRL_A, 8'h00);
    wr(REG_COMPARE_A, 8'h20);
    wr(REG_COUNTER, 8'h80);
    wr(REG_WAVE_CTRL_B, 8'h01);
    wr(REG_FLAGS, 8'h07);
    run(8'h20, 8'h01, 2);
    rd(REG_FLAGS);
    `CHK("blocked match", 1'b0, d[FLAG_MA])
    for (int r = 0; r < 7; r++) begin
      wr(REG_WAVE_CTRL_A, 8'h00);
      wr(REG_COMPARE_A, tr[r][15:8]);
      wr(REG_COMPARE_B, tr[r][7:0]);
      wr(REG_WAVE_CTRL_A, tr[r][31:24]);
      run(8'h00, tr[r][23:16], 300);
      wr(REG_WAVE_CTRL_B, tr[r][23:16]);
      cyc(300);
      hi = 0;
      repeat (1024) begin
        @(negedge mclk);
        hi += (tr[r][29:28] != 2'b00) ? int'(wave_out_b_ff) : int'(wave_out_a_ff);
      end
      stop();
      `CHK("duty", 1'b1, hi >= tx[r] - 10 && hi <= tx[r] + 10)
    end
    @(posedge mclk);
    acks <= 3'h7;
    @(posedge mclk);
    acks <= 3'h0;
    cr(REG_FLAGS, 8'h00);
    report_and_stop();
  end
endmodule
